// ===== hw/dir_guard_map.vh
// Constants for the direction reversal guard
// Assumes a 10 MHz ref_clk and pins synchronised inside the block
//
// Contract
// - The direction input is caught in a direction latch and then passes a two-stage shift register before the decoder.
// - The direction latch follows the direction input while the slow-speed indication is present.
// - All drives are off while latch input differs from its output or shift register input differs from its output.
// - The shift register advances on the PWM oscillator tick, so a change reaches the decoder one to two periods later.
// - Every toggle of the direction input makes a tach pulse whatever the motor speed.
// - The decoder combines the three hall inputs with the delayed direction to pick the high-side and low-side drives.
// - A PWM comparator trip clears the PWM latch and chops the low-side drives for the rest of the cycle; high-side drives stay on.
`ifndef DIR_GUARD_MAP_VH
`define DIR_GUARD_MAP_VH
`define OSC_PERIOD_NS 25000
`define CLK_PERIOD_NS 100
`define OSC_CYCLES (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define TACH_PULSE_CYCLES 4
`define DIR_RESET 1'b0
`endif

// ===== hw/direction_reversal_guard.v
// Direction reversal guard with position decoder and PWM latch
// Assumes all pin inputs are asynchronous to ref_clk
`timescale 1ns/100ps
`include "dir_guard_map.vh"
module direction_reversal_guard #(
	parameter OSC_CYCLES = `OSC_CYCLES,
	parameter TACH_CYCLES = `TACH_PULSE_CYCLES
)(
	// Clock and reset
	input wire ref_clk,
	input wire rst_b,
	// Motor pins
	input wire direction_select,
	input wire slow_speed_sense,
	input wire [2:0] hall_position_inputs,
	input wire pwm_comp_trip,
	// Drives
	output reg [2:0] high_side_drive,
	output reg [2:0] low_side_drive,
	output reg tach_pulse_out,
	output reg osc_tick
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
wire [5:0] pin_raw;
wire [5:0] pin_sync;
wire [2:0] hall_s;
wire dir_in;
wire slow;
wire trip;
assign pin_raw = {pwm_comp_trip, slow_speed_sense, direction_select, hall_position_inputs};
genvar gi;
generate
	for (gi = 0; gi < 6; gi = gi + 1)
	begin : sync_bit
		reg s1_r;
		reg s2_r;
		always @(posedge ref_clk or negedge rst_b)
			if (!rst_b)
			begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
			end
			else
			begin
				s1_r <= pin_raw[gi];
				s2_r <= s1_r;
			end
		assign pin_sync[gi] = s2_r;
	end
endgenerate
assign hall_s = pin_sync[2:0];
assign dir_in = pin_sync[3];
assign slow = pin_sync[4];
assign trip = pin_sync[5];

// ----------------------------------------
// PWM oscillator
// ----------------------------------------
reg [15:0] osc_r;
reg [15:0] osc_nxt;
wire tick;
assign tick = ({16'h0000, osc_r} == OSC_CYCLES - 1);
always @*
begin
	osc_nxt = osc_r + 16'h0001;
	if (tick)
		osc_nxt = 16'h0000;
end
always @(posedge ref_clk or negedge rst_b)
	if (!rst_b)
	begin
		osc_r <= 16'h0000;
		osc_tick <= 1'b0;
	end
	else
	begin
		osc_r <= osc_nxt;
		osc_tick <= tick;
	end

// ----------------------------------------
// Direction latch and shift register
// ----------------------------------------
reg dlatch_r;
reg dlatch_nxt;
reg [1:0] shift_r;
reg [1:0] shift_nxt;
always @*
begin
	dlatch_nxt = dlatch_r;
	if (slow)
		dlatch_nxt = dir_in;
	shift_nxt = shift_r;
	if (tick)
		shift_nxt = {shift_r[0], dlatch_r};
end
always @(posedge ref_clk or negedge rst_b)
	if (!rst_b)
	begin
		dlatch_r <= `DIR_RESET;
		shift_r <= {2{`DIR_RESET}};
	end
	else
	begin
		dlatch_r <= dlatch_nxt;
		shift_r <= shift_nxt;
	end

// ----------------------------------------
// Tach pulse on direction toggle
// ----------------------------------------
reg dir_prev_r;
reg [7:0] tach_r;
reg [7:0] tach_nxt;
reg tach_pulse_out_nxt;
wire toggle;
assign toggle = (dir_prev_r != dir_in);
always @*
begin
	tach_nxt = tach_r;
	if (toggle)
		tach_nxt = TACH_CYCLES[7:0];
	else if (tach_r != 8'h00)
		tach_nxt = tach_r - 8'h01;
	tach_pulse_out_nxt = toggle || (tach_r > 8'h01);
end
always @(posedge ref_clk or negedge rst_b)
	if (!rst_b)
	begin
		dir_prev_r <= `DIR_RESET;
		tach_r <= 8'h00;
		tach_pulse_out <= 1'b0;
	end
	else
	begin
		dir_prev_r <= dir_in;
		tach_r <= tach_nxt;
		tach_pulse_out <= tach_pulse_out_nxt;
	end

// ----------------------------------------
// PWM latch
// ----------------------------------------
reg pwm_latch_r;
reg pwm_latch_nxt;
always @*
begin
	pwm_latch_nxt = pwm_latch_r;
	if (trip)
		pwm_latch_nxt = 1'b0;
	else if (tick)
		pwm_latch_nxt = 1'b1;
end
always @(posedge ref_clk or negedge rst_b)
	if (!rst_b)
		pwm_latch_r <= 1'b0;
	else
		pwm_latch_r <= pwm_latch_nxt;

// ----------------------------------------
// Position decoder
// ----------------------------------------
function [5:0] decode;
	input [2:0] h;
	input d;
	reg [5:0] f;
	begin
		case (h)
			3'b101: f = {3'b001, 3'b010};
			3'b100: f = {3'b001, 3'b100};
			3'b110: f = {3'b010, 3'b100};
			3'b010: f = {3'b010, 3'b001};
			3'b011: f = {3'b100, 3'b001};
			3'b001: f = {3'b100, 3'b010};
			default: f = 6'h00;
		endcase
		decode = d ? {f[2:0], f[5:3]} : f;
	end
endfunction

// ----------------------------------------
// Drive outputs
// ----------------------------------------
wire inhibit;
wire [5:0] sel;
reg [2:0] hs_nxt;
reg [2:0] ls_nxt;
assign inhibit = (dir_in != dlatch_r) || (dlatch_r != shift_r[1]);
assign sel = decode(hall_s, shift_r[1]);
always @*
begin
	hs_nxt = sel[5:3];
	ls_nxt = sel[2:0];
	if (!pwm_latch_r)
		ls_nxt = 3'h0;
	if (inhibit)
	begin
		hs_nxt = 3'h0;
		ls_nxt = 3'h0;
	end
end
always @(posedge ref_clk or negedge rst_b)
	if (!rst_b)
	begin
		high_side_drive <= 3'h0;
		low_side_drive <= 3'h0;
	end
	else
	begin
		high_side_drive <= hs_nxt;
		low_side_drive <= ls_nxt;
	end
endmodule

// ===== verif/dir_guard_props.sv
// Port assertions for the direction guard
// Assumes a bind onto the top module
`timescale 1ns/100ps
module dir_guard_props #(parameter OSC_CYCLES = 4)(
	input wire ref_clk,
	input wire rst_b,
	input wire direction_select,
	input wire slow_speed_sense,
	input wire pwm_comp_trip,
	input wire [2:0] high_side_drive,
	input wire [2:0] low_side_drive,
	input wire tach_pulse_out,
	input wire osc_tick
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_hs_onehot: assert property ($onehot0(high_side_drive)) else $error("hs");
	a_ls_onehot: assert property ($onehot0(low_side_drive)) else $error("ls");
	a_no_overlap: assert property (!(high_side_drive & low_side_drive)) else $error("ov");
	a_trip_chop: assert property (pwm_comp_trip [*4] |-> ##1 !low_side_drive) else $error("trip");
	a_tick_period: assert property (osc_tick |-> ##OSC_CYCLES osc_tick) else $error("tick");
	a_tach_toggle: assert property ($changed(direction_select) |-> ##[1:6] tach_pulse_out)
		else $error("tach");
	a_dir_inhibit: assert property (($stable(direction_select) [*4] ##0 (high_side_drive != 3'h0))
		##1 ($changed(direction_select) && slow_speed_sense)
		|-> ##[2:3] (!high_side_drive) [*2]) else $error("inh");
	a_fast_hold: assert property (($stable(direction_select) [*4] ##0 (high_side_drive != 3'h0))
		##1 ($changed(direction_select) && !slow_speed_sense)
		##1 (!slow_speed_sense && $stable(direction_select)) [*8] |-> !high_side_drive)
		else $error("hold");
endmodule
bind direction_reversal_guard dir_guard_props #(.OSC_CYCLES(OSC_CYCLES)) props_u (.*);

// ===== verif/hall_model.sv
// Hall sensor model on a six-step sequence
// Assumes step rises away from the clock edge
`timescale 1ns/100ps
module hall_model (
	input wire step,
	output wire [2:0] hall_position_inputs
);
	reg [17:0] seq = 18'o132645;
	assign hall_position_inputs = seq[17:15];
	always @(posedge step) seq <= {seq[14:0], seq[17:15]};
endmodule

// ===== verif/testbench.sv
// Directed then random bench for the direction guard
// Assumes the hall model and the bound checker
`timescale 1ns/100ps
module testbench;
	reg ref_clk = 1'b0, rst_b = 1'b0, direction_select = 1'b0, step = 1'b0;
	reg slow_speed_sense = 1'b1, pwm_comp_trip = 1'b0, t;
	reg [31:0] lfsr = 32'h549b38fd;
	wire [2:0] hall_position_inputs, high_side_drive, low_side_drive;
	wire tach_pulse_out, osc_tick;
	integer miscompares = 0, samples_checked = 0, n, ticks = 0;
	always #50 ref_clk = ~ref_clk;
	hall_model hall_u (.*);
	direction_reversal_guard #(.OSC_CYCLES(4)) dut_u (.*);
	function [31:0] nxt(input [31:0] v);
		nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task cmp(input got, input exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("unexpected %0t %h %h", $time, got, exp);
		end
	end
	endtask
	task stop_test;
	begin
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	initial
	begin
		#200000 miscompares = miscompares + 1;
		stop_test;
	end
	initial
	begin
		repeat (16) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (20) @(negedge ref_clk);
		for (n = 0; n < 5; n = n + 1)
		begin
			t = n == 1 || n == 2;
			slow_speed_sense = n != 2;
			pwm_comp_trip = n == 4;
			repeat (2) @(negedge ref_clk);
			direction_select = direction_select ^ t;
			repeat (4) @(negedge ref_clk);
			cmp(tach_pulse_out, t);
			cmp(|high_side_drive, n == 0 || n == 4);
			repeat (20) @(negedge ref_clk);
			cmp(|high_side_drive, n != 2);
			cmp(|low_side_drive, n == 0 || n == 1 || n == 3);
		end
		for (n = 0; n < 400; n = n + 1)
		begin
			@(negedge ref_clk);
			ticks = ticks + osc_tick;
			lfsr = nxt(lfsr);
			step = lfsr[0];
			slow_speed_sense = lfsr[1] | lfsr[2];
			pwm_comp_trip = lfsr[3] & lfsr[4];
			direction_select = direction_select ^ (lfsr[9:5] == 5'h00);
		end
		cmp(ticks == 100, 1'b1);
		stop_test;
	end
endmodule
